/* File: pkg/acs_cfg.svh */
// constants of the abort computer serial i/o block
// assumes a 25 MHz core clock; included by bare name
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// timing
`define ACS_CLK_MHZ     25
`define ACS_CLK_HZ      (`ACS_CLK_MHZ*1000000)
`define ACS_ISA_KPPS    128
`define ACS_ISA_DIV     ((`ACS_CLK_MHZ*1000)/`ACS_ISA_KPPS)
`define ACS_ISA_PW_NS   1000
`define ACS_ISA_PW      ((`ACS_ISA_PW_NS*`ACS_CLK_MHZ)/1000)
`define ACS_KDU_KPPS    64
`define ACS_KDU_DIV     ((`ACS_CLK_MHZ*1000)/`ACS_KDU_KPPS)
`define ACS_KDU_PW_NS   2000
`define ACS_KDU_PW      ((`ACS_KDU_PW_NS*`ACS_CLK_MHZ)/1000)
`define ACS_ALT_PER_SEC 5
`define ACS_ALT_PERIOD  (`ACS_CLK_HZ/`ACS_ALT_PER_SEC)
// word formats
`define ACS_DL_BITS     24
`define ACS_DL_ID_BITS  6
`define ACS_KDU_BITS    36
`define ACS_ALT_BITS    15
`define ACS_PG_KEEP     16
`define ACS_PG_GROUPS   8
`define ACS_PG_DATA     4
// pin vector positions
`define ACS_PIN_DSTART  0
`define ACS_PIN_DSTOP   1
`define ACS_PIN_DSHIFT  2
`define ACS_PIN_PCLK    3
`define ACS_PIN_PDAT    4
`define ACS_PIN_PGATE   5
`define ACS_PIN_KREQ    6
`define ACS_PIN_DISC    7
`define ACS_PIN_KADDR   12
`define ACS_NPIN        21
// register byte offsets
`define ACS_OFF_DLWORD  8'h00
`define ACS_OFF_ALT     8'h04
`define ACS_OFF_ALTR    8'h08
`define ACS_OFF_KDULO   8'h0C
`define ACS_OFF_KDUHI   8'h10
`define ACS_OFF_CTRL    8'h14
`define ACS_OFF_STATUS  8'h18
`define ACS_OFF_INITSEL 8'h1C
`define ACS_OFF_INITDAT 8'h20
// reset values
`define ACS_RST_DLWORD  24'h00_0000
`define ACS_RST_CMD     3'h0
`endif

/* File: pkg/acs_pkg.sv */
// types of the abort computer serial i/o block
// assumes acs_cfg.svh on the include path
`include "acs_cfg.svh"
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_STANDBY  = 2'b00,
      ACS_FOLLOW   = 2'b01,
      ACS_INERTIAL = 2'b10,
      ACS_AUTO     = 2'b11
   } acs_mode_type;
   typedef enum logic {
      ACS_IDLE = 1'b0,
      ACS_RUN  = 1'b1
   } acs_ser_type;
   typedef struct packed {
      logic [`ACS_NPIN-1:0]    sa;
      logic [`ACS_NPIN-1:0]    sb;
      logic [`ACS_NPIN-1:0]    sc;
      logic [`ACS_NPIN-1:0]    filt;
      logic                    hready;
      logic                    hresp;
      logic [31:0]             hrdata;
      logic                    wr_pend;
      logic [7:0]              wr_addr;
      logic [`ACS_DL_BITS-1:0] dl_word;
      logic [`ACS_DL_BITS-1:0] dl_sh;
      logic                    dl_act;
      logic                    dl_out;
      logic [7:0]              isa_cnt;
      logic                    isa_out;
      logic [`ACS_KDU_BITS-1:0] kdu_val;
      logic [`ACS_KDU_BITS-1:0] kdu_sh;
      acs_ser_type             kdu_st;
      logic [8:0]              kdu_cnt;
      logic [5:0]              kdu_bit;
      logic [8:0]              kdu_addr;
      logic                    kdu_dat;
      logic                    kdu_shp;
      logic [`ACS_ALT_BITS-1:0] alt;
      logic [`ACS_ALT_BITS-1:0] altr;
      logic [`ACS_ALT_BITS-1:0] alt_sh;
      logic [`ACS_ALT_BITS-1:0] altr_sh;
      acs_ser_type             alt_st;
      logic [31:0]             alt_per;
      logic [8:0]              alt_cnt;
      logic [3:0]              alt_bit;
      logic                    alt_d;
      logic                    altr_d;
      logic                    alt_shp;
      logic [15:0]             pg_sh;
      logic [4:0]              pg_n;
      logic [9:0]              pg_idx;
      logic [2:0]              pg_pos;
      logic                    pg_have;
      logic [31:0][14:0]       slots;
      logic [4:0]              init_sel;
      acs_mode_type            mode;
      logic [2:0]              cmd;
      logic                    eng_on;
      logic                    eng_cut;
      logic                    steer;
      logic                    tot_en;
      logic                    err_en;
   } acs_state_type;
endpackage

/* File: hw/acs_top.sv */
// abort computer serial i/o: downlink, sync, readout, altitude, init parse
// assumes an ahb-lite master on i_mclk; all pins asynchronous to i_mclk
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "acs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// How it works
// [RULE_01] downlink word: six id bits, 18 data
// [RULE_02] downlink serialised msb first
// [RULE_03] start loads, shift advances, stop ends word
// [RULE_04] fifty words per second, paced by instrumentation
// [RULE_05] 128 kpps sync train to sensor assembly
// [RULE_06] readout request sends preselected parameter value
// [RULE_07] keypad selects addresses up to 511
// [RULE_08] separate shift pulse beside readout data
// [RULE_09] readout is 36-bit bcd at 64 kpps
// [RULE_10] altitude 15 bits msb first, 5/s
// [RULE_11] altitude rate sign plus 14-bit magnitude
// [RULE_12] eight groups: id word then four data
// [RULE_13] drop two words after absolute time
// [RULE_14] discrete grounded reads one, open zero
// [RULE_15] engine and steering only during abort
// [RULE_16] total attitude driven except in standby
// [RULE_17] attitude error only in inertial mode
// [RULE_18] keep first 16 bits; lead bit marks data
// [RULE_19] id: five zeros, 10-bit index; data sign+14
// [RULE_20] double words: most significant half first
// [RULE_21] init repeated ten times, never interleaved
// [RULE_22] shifts outside start-stop ignored, line idles low
// [RULE_23] data before first id ignored; slot by index
module acs_top #(
   parameter int unsigned P_ALT_PERIOD = `ACS_ALT_PERIOD
) (
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_dl_start,
   input  wire logic        i_dl_stop,
   input  wire logic        i_dl_shift,
   output logic             o_dl_data,
   output logic             o_isa_sync,
   input  wire logic        i_kdu_req,
   input  wire logic [8:0]  i_kdu_addr,
   output logic             o_kdu_data,
   output logic             o_kdu_shift,
   output logic             o_alt_data,
   output logic             o_alt_shift,
   output logic             o_altr_data,
   output logic             o_altr_shift,
   input  wire logic        i_pgc_clk,
   input  wire logic        i_pgc_data,
   input  wire logic        i_pgc_gate,
   input  wire logic [4:0]  i_mode_gnd_n,
   output logic             o_engine_on,
   output logic             o_engine_cut,
   output logic             o_steer_en,
   output logic             o_total_att_en,
   output logic             o_att_err_en
);
   acs_pkg::acs_state_type s;
   acs_pkg::acs_state_type n;
   logic [`ACS_NPIN-1:0]   pins;
   logic [`ACS_NPIN-1:0]   agree;
   logic [`ACS_NPIN-1:0]   flt;
   logic [`ACS_NPIN-1:0]   rise;
   logic [4:0]             disc;
   logic                   abort;
   logic [15:0]            pw;
   logic                   pg_done;
   logic                   pg_store;
   logic                   pg_drop;
   logic [31:0]            rd;

   // pins gathered so one three-stage filter serves them all
   assign pins = {i_kdu_addr, i_mode_gnd_n, i_kdu_req, i_pgc_gate,
                  i_pgc_data, i_pgc_clk, i_dl_shift, i_dl_stop, i_dl_start};
   // a change counts only once stages two and three agree
   assign agree = ~(s.sb ^ s.sc);
   assign flt   = (s.sb & agree) | (s.filt & ~agree);
   assign rise  = flt & ~s.filt;
   // grounded input pulls low, which reads as one
   assign disc  = ~flt[`ACS_PIN_DISC +: 5];              // [RULE_14]
   assign abort = disc[3] | disc[4];
   assign pw    = {s.pg_sh[14:0], flt[`ACS_PIN_PDAT]};

   // whole next state
   always_comb begin
      n = s;
      pg_done = 1'b0;
      pg_store = 1'b0;
      pg_drop = 1'b0;
      rd = 32'h0000_0000;
      n.sa = pins;
      n.sb = s.sa;
      n.sc = s.sb;
      n.filt = flt;
      n.hready = 1'b1;
      n.hresp = 1'b0;
      // bus write lands in the data phase
      n.wr_pend = i_hsel & i_hready & i_htrans[1] & i_hwrite;
      n.wr_addr = i_haddr[7:0];
      if (s.wr_pend) begin
         case (s.wr_addr)
            `ACS_OFF_DLWORD:  n.dl_word = i_hwdata[23:0];    // [RULE_01]
            `ACS_OFF_ALT:     n.alt = i_hwdata[14:0];
            `ACS_OFF_ALTR:    n.altr = i_hwdata[14:0];       // [RULE_11]
            `ACS_OFF_KDULO:   n.kdu_val[31:0] = i_hwdata;
            `ACS_OFF_KDUHI:   n.kdu_val[35:32] = i_hwdata[3:0];
            `ACS_OFF_CTRL: begin
               n.mode = acs_pkg::acs_mode_type'(i_hwdata[1:0]);
               n.cmd = i_hwdata[4:2];
            end
            `ACS_OFF_INITSEL: n.init_sel = i_hwdata[4:0];
            default: ;
         endcase
      end
      // downlink serializer; start wins over stop and shift
      if (rise[`ACS_PIN_DSTART]) begin
         n.dl_act = 1'b1;                                    // [RULE_03]
         n.dl_sh = s.dl_word;
      end else if (rise[`ACS_PIN_DSTOP]) begin
         n.dl_act = 1'b0;                                    // [RULE_03]
      end else if (rise[`ACS_PIN_DSHIFT] && s.dl_act) begin
         n.dl_sh = {s.dl_sh[22:0], 1'b0};                    // [RULE_22]
      end
      // word rate is the instrumentation's pacing   [RULE_04]
      n.dl_out = n.dl_act & n.dl_sh[23];                     // [RULE_02]
      // sensor sync: free running, one short pulse per period
      if (s.isa_cnt == 8'(`ACS_ISA_DIV - 1)) begin
         n.isa_cnt = 8'h00;
      end else begin
         n.isa_cnt = s.isa_cnt + 8'h01;
      end
      n.isa_out = n.isa_cnt < 8'(`ACS_ISA_PW);               // [RULE_05]
      // keypad readout; data settles half a bit before its shift
      case (s.kdu_st)
         acs_pkg::ACS_IDLE: begin
            n.kdu_shp = 1'b0;
            n.kdu_dat = 1'b0;
            if (rise[`ACS_PIN_KREQ]) begin
               n.kdu_st = acs_pkg::ACS_RUN;                  // [RULE_06]
               n.kdu_sh = s.kdu_val;
               n.kdu_cnt = 9'h000;
               n.kdu_bit = 6'h00;
               n.kdu_addr = flt[`ACS_PIN_KADDR +: 9];        // [RULE_07]
               n.kdu_dat = s.kdu_val[35];
            end
         end
         acs_pkg::ACS_RUN: begin
            n.kdu_cnt = s.kdu_cnt + 9'h001;
            n.kdu_shp = (s.kdu_cnt >= 9'(`ACS_KDU_DIV / 2)) &&   // [RULE_08]
                        (s.kdu_cnt < 9'(`ACS_KDU_DIV / 2 + `ACS_KDU_PW));
            if (s.kdu_cnt == 9'(`ACS_KDU_DIV - 1)) begin
               n.kdu_cnt = 9'h000;                           // [RULE_09]
               n.kdu_sh = {s.kdu_sh[34:0], 1'b0};
               n.kdu_bit = s.kdu_bit + 6'h01;
               if (s.kdu_bit == 6'(`ACS_KDU_BITS - 1)) begin
                  n.kdu_st = acs_pkg::ACS_IDLE;
               end
            end
            n.kdu_dat = (n.kdu_st == acs_pkg::ACS_RUN) & n.kdu_sh[35];
         end
         default: n.kdu_st = acs_pkg::ACS_IDLE;
      endcase
      // altitude pair: period timer restarts both words together
      if (s.alt_per == P_ALT_PERIOD - 1) begin
         n.alt_per = 32'h0000_0000;
      end else begin
         n.alt_per = s.alt_per + 32'h0000_0001;
      end
      case (s.alt_st)
         acs_pkg::ACS_IDLE: begin
            n.alt_shp = 1'b0;
            n.alt_d = 1'b0;
            n.altr_d = 1'b0;
            if (s.alt_per == P_ALT_PERIOD - 1) begin
               n.alt_st = acs_pkg::ACS_RUN;                  // [RULE_10]
               n.alt_sh = s.alt;
               n.altr_sh = s.altr;
               n.alt_cnt = 9'h000;
               n.alt_bit = 4'h0;
               n.alt_d = s.alt[14];
               n.altr_d = s.altr[14];                        // [RULE_11]
            end
         end
         acs_pkg::ACS_RUN: begin
            n.alt_cnt = s.alt_cnt + 9'h001;
            n.alt_shp = (s.alt_cnt >= 9'(`ACS_KDU_DIV / 2)) &&
                        (s.alt_cnt < 9'(`ACS_KDU_DIV / 2 + `ACS_KDU_PW));
            if (s.alt_cnt == 9'(`ACS_KDU_DIV - 1)) begin
               n.alt_cnt = 9'h000;
               n.alt_sh = {s.alt_sh[13:0], 1'b0};
               n.altr_sh = {s.altr_sh[13:0], 1'b0};
               n.alt_bit = s.alt_bit + 4'h1;
               if (s.alt_bit == 4'(`ACS_ALT_BITS - 1)) begin
                  n.alt_st = acs_pkg::ACS_IDLE;
               end
            end
            n.alt_d = (n.alt_st == acs_pkg::ACS_RUN) & n.alt_sh[14];
            n.altr_d = (n.alt_st == acs_pkg::ACS_RUN) & n.altr_sh[14];
         end
         default: n.alt_st = acs_pkg::ACS_IDLE;
      endcase
      // guidance link: count bits inside the gate, keep sixteen
      if (rise[`ACS_PIN_PGATE]) begin
         n.pg_n = 5'h00;
      end else if (rise[`ACS_PIN_PCLK] && flt[`ACS_PIN_PGATE] &&
                   s.pg_n < 5'(`ACS_PG_KEEP)) begin
         n.pg_sh = pw;                                       // [RULE_18]
         n.pg_n = s.pg_n + 5'h01;
         pg_done = (s.pg_n == 5'(`ACS_PG_KEEP - 1));
      end
      // sender keeps id then four data, uninterrupted  [RULE_12] [RULE_21]
      if (pg_done && !pw[15]) begin
         n.pg_idx = pw[9:0];                                 // [RULE_19]
         n.pg_pos = 3'h0;
         n.pg_have = (pw[14:10] == 5'h00) &&
                     (pw[9:0] < 10'(`ACS_PG_GROUPS));
      end else if (pg_done && s.pg_have &&
                   s.pg_pos < 3'(`ACS_PG_DATA)) begin
         pg_drop = (s.pg_idx == 10'(`ACS_PG_GROUPS - 1)) &&
                   (s.pg_pos >= 3'h2);                       // [RULE_13]
         pg_store = !pg_drop;
         n.pg_pos = s.pg_pos + 3'h1;
      end
      // even slot holds the upper half of a pair           [RULE_20]
      if (pg_store) begin
         n.slots[{s.pg_idx[2:0], s.pg_pos[1:0]}] = pw[14:0];   // [RULE_23]
      end
      // discrete-gated engine outputs, mode-gated attitude outputs
      n.eng_on = abort & s.cmd[0];                           // [RULE_15]
      n.eng_cut = abort & s.cmd[1];
      n.steer = abort & s.cmd[2];
      n.tot_en = s.mode != acs_pkg::ACS_STANDBY;             // [RULE_16]
      n.err_en = s.mode == acs_pkg::ACS_INERTIAL;            // [RULE_17]
      // read mux sees this cycle's write, so no stale read-back
      case (i_haddr[7:0])
         `ACS_OFF_DLWORD:  rd = {8'h00, n.dl_word};
         `ACS_OFF_ALT:     rd = {17'h0_0000, n.alt};
         `ACS_OFF_ALTR:    rd = {17'h0_0000, n.altr};
         `ACS_OFF_KDULO:   rd = n.kdu_val[31:0];
         `ACS_OFF_KDUHI:   rd = {28'h000_0000, n.kdu_val[35:32]};
         `ACS_OFF_CTRL:    rd = {27'h000_0000, n.cmd, n.mode};
         `ACS_OFF_STATUS:  rd = {6'h00, n.pg_idx, n.pg_have, n.dl_act,
                                 n.kdu_addr, disc};
         `ACS_OFF_INITSEL: rd = {27'h000_0000, n.init_sel};
         `ACS_OFF_INITDAT: rd = {17'h0_0000, n.slots[n.init_sel]};
         default:          rd = 32'h0000_0000;
      endcase
      n.hrdata = (i_hsel & i_hready & i_htrans[1] & ~i_hwrite) ?
                 rd : 32'h0000_0000;
   end

   // single state register with synchronous reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s <= '0;
         s.hready <= 1'b1;
         // wrap value, so the first sync period after reset is a full one
         s.isa_cnt <= 8'(`ACS_ISA_DIV - 1);
         s.dl_word <= `ACS_RST_DLWORD;
         s.cmd <= `ACS_RST_CMD;
      end else begin
         s <= n;
      end
   end

   // outputs straight from state flops
   assign o_hrdata = s.hrdata;
   assign o_hreadyout = s.hready;
   assign o_hresp = s.hresp;
   assign o_dl_data = s.dl_out;
   assign o_isa_sync = s.isa_out;
   assign o_kdu_data = s.kdu_dat;
   assign o_kdu_shift = s.kdu_shp;
   assign o_alt_data = s.alt_d;
   assign o_alt_shift = s.alt_shp;
   assign o_altr_data = s.altr_d;
   assign o_altr_shift = s.alt_shp;
   assign o_engine_on = s.eng_on;
   assign o_engine_cut = s.eng_cut;
   assign o_steer_en = s.steer;
   assign o_total_att_en = s.tot_en;
   assign o_att_err_en = s.err_en;

   // checks
   AST_DL_IDLE: assert property (@(posedge i_mclk) disable iff (i_srst)
      !s.dl_act |-> !o_dl_data)                              // [RULE_22]
      else $error("downlink line not idle between words");
   AST_DL_MSB: assert property (@(posedge i_mclk) disable iff (i_srst)
      rise[`ACS_PIN_DSTART] |=> o_dl_data == $past(s.dl_word[23]))   // [RULE_02]
      else $error("downlink word did not start with msb");
   AST_ENG_GATE: assert property (@(posedge i_mclk) disable iff (i_srst)
      !abort |=> !o_engine_on && !o_engine_cut && !o_steer_en)   // [RULE_15]
      else $error("engine command outside abort");
   AST_TOT_STBY: assert property (@(posedge i_mclk) disable iff (i_srst)
      s.mode == acs_pkg::ACS_STANDBY |=> !o_total_att_en)    // [RULE_16]
      else $error("total attitude driven in standby");
   AST_ERR_MODE: assert property (@(posedge i_mclk) disable iff (i_srst)
      o_att_err_en |-> $past(s.mode) == acs_pkg::ACS_INERTIAL)  // [RULE_17]
      else $error("attitude error outside inertial mode");
   AST_ISA_PERIOD: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(o_isa_sync) |-> ##195 $rose(o_isa_sync))         // [RULE_05]
      else $error("sync pulse period wrong");
   AST_KDU_SHIFT: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(o_kdu_shift) |-> $past(s.kdu_st) == acs_pkg::ACS_RUN)   // [RULE_08]
      else $error("readout shift outside a readout");
   AST_PG_DROP: assert property (@(posedge i_mclk) disable iff (i_srst)
      pg_store |-> !(s.pg_idx == 10'h007 && s.pg_pos >= 3'h2))   // [RULE_13]
      else $error("trailing group words were stored");
   AST_ALT_LEN: assert property (@(posedge i_mclk) disable iff (i_srst)
      s.alt_st == acs_pkg::ACS_RUN |-> s.alt_bit < 4'hF)     // [RULE_10]
      else $error("altitude word longer than fifteen bits");
   // stop clears the line, readout length, index decode
   AST_DL_STOP: assert property (@(posedge i_mclk)   // [RULE_03]
      disable iff (i_srst)
      rise[`ACS_PIN_DSTOP] && !rise[`ACS_PIN_DSTART] |=> !o_dl_data)
      else $error("downlink line not cleared by stop");
   AST_KDU_LEN: assert property (@(posedge i_mclk)   // [RULE_09]
      disable iff (i_srst)
      s.kdu_st == acs_pkg::ACS_RUN |-> s.kdu_bit < 6'(`ACS_KDU_BITS))
      else $error("readout word longer than thirty-six bits");
   AST_PG_ID: assert property (@(posedge i_mclk)     // [RULE_19]
      disable iff (i_srst)
      pg_done && pw[15:10] == 6'h00 && pw[9:0] < 10'(`ACS_PG_GROUPS)
      |=> s.pg_have && s.pg_idx == $past(pw[9:0]))
      else $error("valid index word not taken");
   COV_DL: cover property (@(posedge i_mclk) disable iff (i_srst)
      rise[`ACS_PIN_DSTART] ##[1:1000] rise[`ACS_PIN_DSTOP]);
   COV_KDU: cover property (@(posedge i_mclk) disable iff (i_srst)
      $fell(s.kdu_st == acs_pkg::ACS_RUN));
   COV_PG: cover property (@(posedge i_mclk) disable iff (i_srst)
      pg_store);
   COV_ALT: cover property (@(posedge i_mclk) disable iff (i_srst)
      $rose(s.alt_st == acs_pkg::ACS_RUN));
endmodule

`default_nettype wire

/* File: tb/acs_partner.sv */
// far side model: instrumentation control pulses and guidance link sender
// assumes i_mclk at 25 MHz; pulses held 4 clocks to pass 3-flop filters
`timescale 1ns/100ps
`default_nettype none
module acs_partner (
   input  wire logic i_mclk,
   input  wire logic i_dl_data,
   output logic      o_dl_start,
   output logic      o_dl_stop,
   output logic      o_dl_shift,
   output logic      o_pgc_clk,
   output logic      o_pgc_data,
   output logic      o_pgc_gate
);
   logic [2:0] ctl = 3'h0;
   // control pins: 0 start, 1 stop, 2 shift
   assign o_dl_start = ctl[0];
   assign o_dl_stop  = ctl[1];
   assign o_dl_shift = ctl[2];
   initial begin
      {o_pgc_clk, o_pgc_data, o_pgc_gate} = 3'h0;
   end
   // one pulse, then a quiet gap so the line settles
   task automatic dl_pulse(input int k);
      @(posedge i_mclk);
      ctl[k] <= 1'h1;
      repeat (4) @(posedge i_mclk);
      ctl <= 3'h0;
      repeat (8) @(posedge i_mclk);
   endtask
   // start, 24 shifts, stop; pacing left to the caller
   task automatic dl_word(output logic [23:0] w);
      dl_pulse(0);
      w[23] = i_dl_data;
      for (int i = 22; i >= 0; i--) begin
         dl_pulse(2);
         w[i] = i_dl_data; // msb first, id bits lead
      end
      dl_pulse(2);
      dl_pulse(1);
   endtask
   // 40-bit frame, link clock still outside frames
   task automatic pg_word(input logic [15:0] w);
      logic [39:0] f;
      f = {w, 24'hC3_5A96};
      #13 o_pgc_gate = 1'h1;
      for (int i = 39; i >= 0; i--) begin
         #160 o_pgc_clk = 1'h0;
         o_pgc_data = f[i];
         #160 o_pgc_clk = 1'h1;
      end
      #160 o_pgc_clk = 1'h0;
      #160 o_pgc_gate = 1'h0;
      o_pgc_data = ~o_pgc_data; // released line shows no stale bit
      #640;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_abort_computer_serial_io.sv */
// self-checking bench of the abort computer serial i/o block
// assumes acs_cfg.svh on the include path and acs_partner alongside
`include "acs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_abort_computer_serial_io;
   localparam int ALT_PER = 8000;
   logic        mclk   = 1'h0;
   logic        srst   = 1'h1;
   logic        hsel   = 1'h0;
   logic [31:0] haddr  = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [2:0]  hsize  = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        kreq   = 1'h0;
   logic [8:0]  kaddr  = 9'h000;
   logic [4:0]  gnd_n  = 5'h1F;
   logic [31:0] hrdata;
   logic        rdy, resp, dl_d, dstart, dstop, dshift, isa, kd, ks;
   logic        alt_d, alt_s, rt_d, rt_s, pclk, pdat, pgate;
   logic        eng_on, eng_cut, steer, tot_en, err_en;
   int          n_mismatch  = 0;
   int          checks_done = 0;
   // 25 MHz core clock
   always #20 mclk = ~mclk;
   acs_top #(.P_ALT_PERIOD(ALT_PER)) DUT (
      .i_mclk(mclk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
      .o_hreadyout(rdy), .o_hresp(resp), .i_dl_start(dstart),
      .i_dl_stop(dstop), .i_dl_shift(dshift), .o_dl_data(dl_d),
      .o_isa_sync(isa), .i_kdu_req(kreq), .i_kdu_addr(kaddr),
      .o_kdu_data(kd), .o_kdu_shift(ks), .o_alt_data(alt_d),
      .o_alt_shift(alt_s), .o_altr_data(rt_d), .o_altr_shift(rt_s),
      .i_pgc_clk(pclk), .i_pgc_data(pdat), .i_pgc_gate(pgate),
      .i_mode_gnd_n(gnd_n), .o_engine_on(eng_on),
      .o_engine_cut(eng_cut), .o_steer_en(steer),
      .o_total_att_en(tot_en), .o_att_err_en(err_en));
   acs_partner PRT (
      .i_mclk(mclk), .i_dl_data(dl_d), .o_dl_start(dstart),
      .o_dl_stop(dstop), .o_dl_shift(dshift), .o_pgc_clk(pclk),
      .o_pgc_data(pdat), .o_pgc_gate(pgate));
   task automatic finish_test;
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [35:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rdy !== 1'h1 && n < 50);
      if (rdy !== 1'h1) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      hsel   <= 1'h1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      wait_rdy();
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'h1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [35:0] e,
                      input string nm);
      logic [31:0] r;
      ahb(1'h0, a, 32'h0000_0000, r);
      chk(nm, e, {4'h0, r});
   endtask
   // select a stored slot, let it settle, read it back
   task automatic slot(input int s, input logic [14:0] e);
      wr(`ACS_OFF_INITSEL, s);
      repeat (2) @(posedge mclk);
      rdc(`ACS_OFF_INITDAT, e, "init slot");
   endtask
   // collect bits at shift rises; altitude words start after a long gap
   task automatic grab(input int sel, input int n, output logic [35:0] w);
      logic s, d, p;
      int   k, gap, t;
      p = 1'h1;
      k = 0;
      gap = 0;
      w = '0;
      for (t = 0; t < 20000 && k < n; t++) begin
         @(posedge mclk);
         s = sel == 0 ? ks : sel == 1 ? alt_s : rt_s;
         d = sel == 0 ? kd : sel == 1 ? alt_d : rt_d;
         if (s && !p && (sel == 0 || gap > 500 || k > 0)) begin
            w = {w[34:0], d};
            k++;
         end
         gap = s ? 0 : gap + 1;
         p = s;
      end
      if (k < n) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // cycles between sync rises and cycles high
   task automatic isa_meas(output int per, hi);
      logic p;
      int   t, r0;
      p = 1'h1;
      r0 = -1;
      hi = 0;
      per = 0;
      for (t = 0; t < 1000 && per == 0; t++) begin
         @(posedge mclk);
         if (isa && !p && r0 >= 0) per = t - r0;
         if (isa && !p && r0 < 0) r0 = t;
         if (isa && r0 >= 0 && per == 0) hi++;
         p = isa;
      end
   endtask
   // hang guard
   initial begin
      repeat (90000) @(posedge mclk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      logic [31:0] r;
      logic [35:0] w;
      logic [23:0] dw;
      logic [4:0]  pat [3];
      int          per, hi;
      pat = '{5'h1F, 5'h17, 5'h0F};
      repeat (20) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      chk("hreadyout", 36'h1, rdy);
      chk("hresp", 36'h0, resp);
      rdc(`ACS_OFF_DLWORD, `ACS_RST_DLWORD, "dlword reset");
      wr(8'h24, 32'hFFFF_FFFF);
      rdc(8'h24, 36'h0, "unmapped");
      // stray shift while idle, then two words and a shift after stop
      PRT.dl_pulse(2);
      chk("dl idle shift", 36'h0, dl_d);
      for (int i = 0; i < 2; i++) begin
         wr(`ACS_OFF_DLWORD, i ? 32'h003F_FFFE : 32'h00A5_C396);
         PRT.dl_word(dw);
         chk("dl word", i ? 36'h3F_FFFE : 36'hA5_C396, dw);
         chk("dl after stop", 36'h0, dl_d);
      end
      PRT.dl_pulse(2);
      chk("dl late shift", 36'h0, dl_d);
      // data before any index, then groups 1 and 7, ms half first
      PRT.pg_word(16'hC001);
      PRT.pg_word(16'h0001);
      for (int i = 0; i < 4; i++) PRT.pg_word(16'h8000 | 16'h1111 * (i + 1));
      PRT.pg_word(16'h0007);
      for (int i = 0; i < 4; i++) PRT.pg_word(16'h8000 | 16'h0123 * (i + 1));
      slot(0, 15'h0000);
      for (int i = 0; i < 4; i++) slot(4 + i, 15'h1111 * (i + 1));
      for (int i = 0; i < 2; i++) slot(28 + i, 15'h0123 * (i + 1));
      for (int i = 2; i < 4; i++) slot(28 + i, 15'h0000);
      ahb(1'h0, `ACS_OFF_STATUS, 32'h0000_0000, r);
      chk("init index", 36'h00F, r[25:15]);
      // open, abort and abort stage discretes with all commands set
      wr(`ACS_OFF_CTRL, 32'h0000_001E);
      for (int i = 0; i < 3; i++) begin
         gnd_n <= pat[i];
         repeat (10) @(posedge mclk);
         chk("engine", i ? 36'h7 : 36'h0, {eng_on, eng_cut, steer});
         ahb(1'h0, `ACS_OFF_STATUS, 32'h0000_0000, r);
         chk("discretes", 5'(~pat[i]), r[4:0]);
      end
      // every display mode
      for (int m = 0; m < 4; m++) begin
         wr(`ACS_OFF_CTRL, m);
         repeat (3) @(posedge mclk);
         chk("total att", m != 0, tot_en);
         chk("att err", m == 2, err_en);
      end
      // readout at the top address
      wr(`ACS_OFF_KDULO, 32'h8765_4321);
      wr(`ACS_OFF_KDUHI, 32'h0000_0009);
      kaddr <= 9'h1FF;
      kreq  <= 1'h1;
      grab(0, 36, w);
      kreq  <= 1'h0;
      chk("readout", 36'h9_8765_4321, w);
      ahb(1'h0, `ACS_OFF_STATUS, 32'h0000_0000, r);
      chk("kdu addr", 36'h1FF, r[13:5]);
      // altitude and signed rate words
      wr(`ACS_OFF_ALT, 32'h0000_5A3C);
      wr(`ACS_OFF_ALTR, 32'h0000_4123);
      grab(1, 15, w);
      chk("altitude", 36'h5A3C, w);
      grab(2, 15, w);
      chk("alt rate", 36'h4123, w);
      isa_meas(per, hi);
      chk("sync period", `ACS_ISA_DIV, per);
      chk("sync width", `ACS_ISA_PW, hi);
      finish_test();
   end
endmodule
`default_nettype wire
